// File: hdl/clbe_regs.vh
`ifndef CLBE_REGS_VH
`define CLBE_REGS_VH
// Operation select codes
`define CLBE_OP_OR_IMM 5'h00
`define CLBE_OP_ANDN_IMM 5'h01
`define CLBE_OP_TEST_ZN 5'h02
`define CLBE_OP_ADD_ONE 5'h03
`define CLBE_OP_SUB_ONE 5'h04
`define CLBE_OP_ZERO_REG 5'h05
`define CLBE_OP_FILL_ONES 5'h06
`define CLBE_OP_REL_JUMP 5'h07
`define CLBE_OP_JUMP_PTR 5'h08
`define CLBE_OP_REL_CALL 5'h09
`define CLBE_OP_CALL_PTR 5'h0A
`define CLBE_OP_POP_PC 5'h0B
`define CLBE_OP_IRQ_EXIT 5'h0C
`define CLBE_OP_CMP_SKIP_EQ 5'h0D
`define CLBE_OP_CMP_IMM 5'h0E
`define CLBE_OP_SKIP_REG_CLR 5'h0F
`define CLBE_OP_SKIP_REG_SET 5'h10
`define CLBE_OP_SKIP_IO_CLR 5'h11
`define CLBE_OP_SKIP_IO_SET 5'h12
`define CLBE_OP_BR_FLAG_SET 5'h13
`define CLBE_OP_BR_FLAG_CLR 5'h14
`define CLBE_OP_IO_BIT_SET 5'h15
`define CLBE_OP_IO_BIT_CLR 5'h16
`define CLBE_OP_SHIFT_LEFT 5'h17
`define CLBE_OP_SHIFT_RIGHT 5'h18
`define CLBE_OP_ROTATE_LEFT 5'h19
// Flag register bit positions
`define CLBE_FL_C 0
`define CLBE_FL_Z 1
`define CLBE_FL_N 2
`define CLBE_FL_V 3
`define CLBE_FL_S 4
`define CLBE_FL_H 5
`define CLBE_FL_T 6
`define CLBE_FL_I 7
// Reset and fill values
`define CLBE_FLAGS_RST 8'h00
`define CLBE_FILL_VALUE 8'hFF
// Cycle counts
`define CLBE_CYC_ONE 3'h1
`define CLBE_CYC_TWO 3'h2
`define CLBE_CYC_THREE 3'h3
`define CLBE_CYC_FOUR 3'h4
`endif

// File: hdl/clbe_core.v
// Contract
// - or_immediate_bits ORs constant into register, sets Z N V, one cycle.
// - and_not_immediate_bits ANDs with 0xFF minus constant, sets Z N V, one cycle.
// - test_zero_negative ANDs register with itself, sets Z N V, one cycle.
// - jump_via_pointer loads PC from Z pointer, no flags, two cycles.
// - call_via_pointer calls Z pointer target, no flags, three cycles.
// - compare_skip_if_equal skips next on equality, PC plus 2 or 3, 1/2/3 cycles.
// - compare_immediate subtracts constant, no writeback, sets Z N V C H, one cycle.
// - Register bit skip tests chosen bit, skips when clear or set, no flags.
// - I/O bit skip tests chosen I/O bit, skips when clear or set, 1/2/3 cycles.
// - Flag branch tests chosen flag, taken gives PC plus offset plus one, 1/2 cycles.
// - Signed ge taken when N xor V is 0, less when 1.
// - Unsigned same-or-higher taken on carry clear, lower on carry set.
// - Half-carry branches follow H flag set or clear, 1/2 cycles.
// - Transfer-flag branches follow T flag set or clear, 1/2 cycles.
// - Overflow branches follow V flag set or clear, 1/2 cycles.
// - Interrupt-state branches follow I flag set or clear, 1/2 cycles.
// - io_bit_set and io_bit_clear force one I/O bit, no flags, two cycles.
// - rotate_left_carry shifts up through carry, sets Z C N V, one cycle.
`timescale 1ns/1ns
`default_nettype none
`include "clbe_regs.vh"
module clbe_core #(
    parameter PC_W = 16
) (
    input wire ref_clk_in,
    input wire reset_n_in,
    input wire start_in,
    input wire [4:0] op_in,
    input wire [7:0] rd_val_in,
    input wire [7:0] rr_val_in,
    input wire [7:0] imm_in,
    input wire [2:0] bit_sel_in,
    input wire [11:0] offset_in,
    input wire [7:0] io_rdata_in,
    input wire [15:0] z_ptr_in,
    input wire [PC_W-1:0] stack_pc_in,
    input wire next_two_word_in,
    output wire busy_out,
    output reg done_out,
    output reg [PC_W-1:0] pc_out,
    output reg [7:0] flags_out,
    output reg [7:0] result_out,
    output reg result_we_out,
    output reg [7:0] io_wdata_out,
    output reg io_we_out,
    output reg push_out,
    output reg [PC_W-1:0] push_data_out,
    output reg pop_out
);

    // Combinational results of the operation being started
    reg [7:0] res;
    reg we;
    reg [7:0] fl;
    reg [PC_W-1:0] pcn;
    reg [2:0] cyc;
    reg push;
    reg pop;
    reg iow;
    reg [7:0] iod;
    reg logic_upd;
    reg shift_upd;
    reg skip;
    reg take;
    reg test_bit;
    reg [8:0] diff;

    // Results held while a multi-cycle operation runs
    reg [1:0] cnt_r;
    reg [7:0] res_r;
    reg we_r;
    reg [7:0] fl_r;
    reg [PC_W-1:0] pc_r;
    reg push_r;
    reg pop_r;
    reg iow_r;
    reg [7:0] iod_r;

    wire [PC_W-1:0] pc_inc;
    wire [PC_W-1:0] off_long;
    wire [PC_W-1:0] off_short;
    wire [7:0] bit_mask;
    wire go;
    wire [1:0] cnt_load;

    // Sequencing helpers
    assign busy_out = (cnt_r != 2'h0);
    assign go = start_in & ~busy_out;
    assign pc_inc = pc_out + {{(PC_W-1){1'b0}}, 1'b1};
    assign off_long = {{(PC_W-12){offset_in[11]}}, offset_in};
    assign off_short = {{(PC_W-7){offset_in[6]}}, offset_in[6:0]};
    assign bit_mask = 8'h01 << bit_sel_in;
    assign cnt_load = cyc[1:0] - 2'h1;

    // Condition selector for flag branches
    always @* begin
        if (bit_sel_in == `CLBE_FL_S) begin
            test_bit = flags_out[`CLBE_FL_N] ^ flags_out[`CLBE_FL_V];
        end else begin
            test_bit = flags_out[bit_sel_in];
        end
    end

    // Operation execution
    always @* begin
        res = rd_val_in;
        we = 1'b0;
        fl = flags_out;
        pcn = pc_inc;
        cyc = `CLBE_CYC_ONE;
        push = 1'b0;
        pop = 1'b0;
        iow = 1'b0;
        iod = io_rdata_in;
        logic_upd = 1'b0;
        shift_upd = 1'b0;
        skip = 1'b0;
        take = 1'b0;
        diff = 9'h000;
        case (op_in)
            `CLBE_OP_OR_IMM: begin
                res = rd_val_in | imm_in;
                we = 1'b1;
                logic_upd = 1'b1;
            end
            `CLBE_OP_ANDN_IMM: begin
                res = rd_val_in & (`CLBE_FILL_VALUE - imm_in);
                we = 1'b1;
                logic_upd = 1'b1;
            end
            `CLBE_OP_TEST_ZN: begin
                res = rd_val_in & rd_val_in;
                we = 1'b1;
                logic_upd = 1'b1;
            end
            `CLBE_OP_ADD_ONE: begin
                res = rd_val_in + 8'h01;
                we = 1'b1;
                logic_upd = 1'b1;
            end
            `CLBE_OP_SUB_ONE: begin
                res = rd_val_in - 8'h01;
                we = 1'b1;
                logic_upd = 1'b1;
            end
            `CLBE_OP_ZERO_REG: begin
                res = rd_val_in ^ rd_val_in;
                we = 1'b1;
                logic_upd = 1'b1;
            end
            `CLBE_OP_FILL_ONES: begin
                res = `CLBE_FILL_VALUE;
                we = 1'b1;
            end
            `CLBE_OP_REL_JUMP: begin
                pcn = pc_inc + off_long;
                cyc = `CLBE_CYC_TWO;
            end
            `CLBE_OP_JUMP_PTR: begin
                pcn = z_ptr_in[PC_W-1:0];
                cyc = `CLBE_CYC_TWO;
            end
            `CLBE_OP_REL_CALL: begin
                pcn = pc_inc + off_long;
                push = 1'b1;
                cyc = `CLBE_CYC_THREE;
            end
            `CLBE_OP_CALL_PTR: begin
                pcn = z_ptr_in[PC_W-1:0];
                push = 1'b1;
                cyc = `CLBE_CYC_THREE;
            end
            `CLBE_OP_POP_PC: begin
                pcn = stack_pc_in;
                pop = 1'b1;
                cyc = `CLBE_CYC_FOUR;
            end
            `CLBE_OP_IRQ_EXIT: begin
                pcn = stack_pc_in;
                pop = 1'b1;
                fl[`CLBE_FL_I] = 1'b1;
                cyc = `CLBE_CYC_FOUR;
            end
            `CLBE_OP_CMP_SKIP_EQ: begin
                skip = (rd_val_in == rr_val_in);
            end
            `CLBE_OP_CMP_IMM: begin
                diff = {1'b0, rd_val_in} - {1'b0, imm_in};
                res = diff[7:0];
                fl[`CLBE_FL_C] = diff[8];
                fl[`CLBE_FL_H] = (~rd_val_in[3] & imm_in[3]) | (imm_in[3] & diff[3])
                    | (diff[3] & ~rd_val_in[3]);
                fl[`CLBE_FL_V] = (rd_val_in[7] & ~imm_in[7] & ~diff[7])
                    | (~rd_val_in[7] & imm_in[7] & diff[7]);
                fl[`CLBE_FL_N] = diff[7];
                fl[`CLBE_FL_Z] = (diff[7:0] == 8'h00);
                fl[`CLBE_FL_S] = diff[7] ^ fl[`CLBE_FL_V];
            end
            `CLBE_OP_SKIP_REG_CLR: begin
                skip = ~rd_val_in[bit_sel_in];
            end
            `CLBE_OP_SKIP_REG_SET: begin
                skip = rd_val_in[bit_sel_in];
            end
            `CLBE_OP_SKIP_IO_CLR: begin
                skip = ~io_rdata_in[bit_sel_in];
            end
            `CLBE_OP_SKIP_IO_SET: begin
                skip = io_rdata_in[bit_sel_in];
            end
            `CLBE_OP_BR_FLAG_SET: begin
                take = test_bit;
            end
            `CLBE_OP_BR_FLAG_CLR: begin
                take = ~test_bit;
            end
            `CLBE_OP_IO_BIT_SET: begin
                iod = io_rdata_in | bit_mask;
                iow = 1'b1;
                cyc = `CLBE_CYC_TWO;
            end
            `CLBE_OP_IO_BIT_CLR: begin
                iod = io_rdata_in & ~bit_mask;
                iow = 1'b1;
                cyc = `CLBE_CYC_TWO;
            end
            `CLBE_OP_SHIFT_LEFT: begin
                res = {rd_val_in[6:0], 1'b0};
                fl[`CLBE_FL_C] = rd_val_in[7];
                we = 1'b1;
                shift_upd = 1'b1;
            end
            `CLBE_OP_SHIFT_RIGHT: begin
                res = {1'b0, rd_val_in[7:1]};
                fl[`CLBE_FL_C] = rd_val_in[0];
                we = 1'b1;
                shift_upd = 1'b1;
            end
            `CLBE_OP_ROTATE_LEFT: begin
                res = {rd_val_in[6:0], flags_out[`CLBE_FL_C]};
                fl[`CLBE_FL_C] = rd_val_in[7];
                we = 1'b1;
                shift_upd = 1'b1;
            end
            default: begin
                pcn = pc_inc;
            end
        endcase
        // Logic-class flags: V cleared, except the overflow cases of add/sub one
        if (logic_upd) begin
            fl[`CLBE_FL_Z] = (res == 8'h00);
            fl[`CLBE_FL_N] = res[7];
            fl[`CLBE_FL_V] = 1'b0;
            if (op_in == `CLBE_OP_ADD_ONE) begin
                fl[`CLBE_FL_V] = (rd_val_in == 8'h7F);
            end
            if (op_in == `CLBE_OP_SUB_ONE) begin
                fl[`CLBE_FL_V] = (rd_val_in == 8'h80);
            end
            fl[`CLBE_FL_S] = res[7] ^ fl[`CLBE_FL_V];
        end
        // Shift-class flags: V is N xor new carry
        if (shift_upd) begin
            fl[`CLBE_FL_Z] = (res == 8'h00);
            fl[`CLBE_FL_N] = res[7];
            fl[`CLBE_FL_V] = res[7] ^ fl[`CLBE_FL_C];
            fl[`CLBE_FL_S] = fl[`CLBE_FL_C];
        end
        // Skip length follows the size of the skipped instruction
        if (skip) begin
            if (next_two_word_in) begin
                pcn = pc_inc + {{(PC_W-2){1'b0}}, 2'h2};
                cyc = `CLBE_CYC_THREE;
            end else begin
                pcn = pc_inc + {{(PC_W-1){1'b0}}, 1'b1};
                cyc = `CLBE_CYC_TWO;
            end
        end
        // Taken branch costs one extra cycle
        if (take) begin
            pcn = pc_inc + off_short;
            cyc = `CLBE_CYC_TWO;
        end
    end

    // Hold and commit sequencer
    always @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            cnt_r <= 2'h0;
            res_r <= 8'h00;
            we_r <= 1'b0;
            fl_r <= `CLBE_FLAGS_RST;
            pc_r <= {PC_W{1'b0}};
            push_r <= 1'b0;
            pop_r <= 1'b0;
            iow_r <= 1'b0;
            iod_r <= 8'h00;
            push_data_out <= {PC_W{1'b0}};
        end else if (go && cyc != `CLBE_CYC_ONE) begin
            cnt_r <= cnt_load;
            res_r <= res;
            we_r <= we;
            fl_r <= fl;
            pc_r <= pcn;
            push_r <= push;
            pop_r <= pop;
            iow_r <= iow;
            iod_r <= iod;
            push_data_out <= pc_inc;
        end else if (busy_out) begin
            cnt_r <= cnt_r - 2'h1;
        end
    end

    // Architectural state and output strobes
    always @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            pc_out <= {PC_W{1'b0}};
            flags_out <= `CLBE_FLAGS_RST;
            result_out <= 8'h00;
            result_we_out <= 1'b0;
            io_wdata_out <= 8'h00;
            io_we_out <= 1'b0;
            push_out <= 1'b0;
            pop_out <= 1'b0;
            done_out <= 1'b0;
        end else begin
            result_we_out <= 1'b0;
            io_we_out <= 1'b0;
            push_out <= 1'b0;
            pop_out <= 1'b0;
            done_out <= 1'b0;
            if (go && cyc == `CLBE_CYC_ONE) begin
                pc_out <= pcn;
                flags_out <= fl;
                result_out <= res;
                result_we_out <= we;
                done_out <= 1'b1;
            end else if (cnt_r == 2'h1) begin
                pc_out <= pc_r;
                flags_out <= fl_r;
                result_out <= res_r;
                result_we_out <= we_r;
                io_wdata_out <= iod_r;
                io_we_out <= iow_r;
                push_out <= push_r;
                pop_out <= pop_r;
                done_out <= 1'b1;
            end
        end
    end

endmodule
`default_nettype wire

// File: tb/clbe_chk.sv
`timescale 1ns/1ns
`default_nettype none
`include "clbe_regs.vh"
module clbe_chk #(
    parameter PC_W = 16
) (
    input wire logic ref_clk_in,
    input wire logic reset_n_in,
    input wire logic start_in,
    input wire logic [4:0] op_in,
    input wire logic [7:0] rd_val_in,
    input wire logic [7:0] rr_val_in,
    input wire logic [7:0] imm_in,
    input wire logic [2:0] bit_sel_in,
    input wire logic [11:0] offset_in,
    input wire logic [7:0] io_rdata_in,
    input wire logic [15:0] z_ptr_in,
    input wire logic [PC_W-1:0] stack_pc_in,
    input wire logic next_two_word_in,
    input wire logic busy_out,
    input wire logic done_out,
    input wire logic [PC_W-1:0] pc_out,
    input wire logic [7:0] flags_out,
    input wire logic [7:0] result_out,
    input wire logic result_we_out,
    input wire logic [7:0] io_wdata_out,
    input wire logic io_we_out,
    input wire logic push_out,
    input wire logic [PC_W-1:0] push_data_out,
    input wire logic pop_out
);
    // Accepted start and low pointer bits
    wire logic go;
    wire logic [PC_W-1:0] z_low;
    assign go = start_in & ~busy_out;
    assign z_low = z_ptr_in[PC_W-1:0];
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (!reset_n_in);
    // Logic and compare results one cycle after the accepting edge
    or_imm_result_a: assert property (go && op_in == `CLBE_OP_OR_IMM |=> done_out &&
        result_we_out && result_out == ($past(rd_val_in) | $past(imm_in)))
        else $error("or result wrong");
    andn_imm_result_a: assert property (go && op_in == `CLBE_OP_ANDN_IMM |=>
        result_we_out && result_out == ($past(rd_val_in) & ~$past(imm_in)))
        else $error("and-not result wrong");
    cmp_no_write_a: assert property (go && op_in == `CLBE_OP_CMP_IMM |=> done_out &&
        !result_we_out && flags_out[1] == ($past(rd_val_in) == $past(imm_in)))
        else $error("compare wrote back or zero flag wrong");
    // Multi-cycle control transfers, I/O bit writes and one-cycle fill ones
    jump_ptr_target_a: assert property (go && op_in == `CLBE_OP_JUMP_PTR |=> busy_out
        ##1 (done_out && pc_out == $past(z_low, 2) && $stable(flags_out)))
        else $error("pointer jump wrong");
    call_ptr_timing_a: assert property (go && op_in == `CLBE_OP_CALL_PTR |=>
        busy_out[*2] ##1 (!busy_out && done_out && push_out && pc_out == $past(z_low, 3)))
        else $error("pointer call wrong");
    return_timing_a: assert property (go && op_in == `CLBE_OP_POP_PC |=>
        busy_out[*3] ##1 (done_out && pop_out && pc_out == $past(stack_pc_in, 4)))
        else $error("return wrong");
    io_set_bit_a: assert property (go && op_in == `CLBE_OP_IO_BIT_SET |=> busy_out ##1
        (io_we_out && io_wdata_out == ($past(io_rdata_in, 2) | (8'h01 << $past(bit_sel_in, 2)))))
        else $error("io bit set wrong");
    io_write_flags_a: assert property (io_we_out |-> done_out && $stable(flags_out))
        else $error("io write touched flags");
    fill_ones_a: assert property (go && op_in == `CLBE_OP_FILL_ONES |=>
        result_out == 8'hFF && $stable(flags_out))
        else $error("fill ones wrong");
endmodule
bind clbe_core clbe_chk #(.PC_W(PC_W)) u_chk (.ref_clk_in(ref_clk_in), .reset_n_in(reset_n_in),
    .start_in(start_in), .op_in(op_in), .rd_val_in(rd_val_in), .rr_val_in(rr_val_in),
    .imm_in(imm_in), .bit_sel_in(bit_sel_in), .offset_in(offset_in), .io_rdata_in(io_rdata_in),
    .z_ptr_in(z_ptr_in), .stack_pc_in(stack_pc_in), .next_two_word_in(next_two_word_in),
    .busy_out(busy_out), .done_out(done_out), .pc_out(pc_out), .flags_out(flags_out),
    .result_out(result_out), .result_we_out(result_we_out), .io_wdata_out(io_wdata_out),
    .io_we_out(io_we_out), .push_out(push_out), .push_data_out(push_data_out), .pop_out(pop_out));
`default_nettype wire

// File: tb/clbe_tb.sv
`timescale 1ns/1ns
`default_nettype none
`include "clbe_regs.vh"
module tb;
    logic ref_clk_in = 1'b0, reset_n_in = 1'b0, start_in = 1'b0, next_two_word_in = 1'b0;
    logic [4:0] op_in = 5'h00;
    logic [7:0] rd_val_in = 8'h00, rr_val_in = 8'h00, imm_in = 8'h00, io_rdata_in = 8'h00;
    logic [2:0] bit_sel_in = 3'h0;
    logic [11:0] offset_in = 12'h000;
    logic [15:0] z_ptr_in = 16'h0000, stack_pc_in = 16'h0000, pc = 16'h0000, old;
    wire logic busy_out, done_out, result_we_out, io_we_out, push_out, pop_out;
    wire logic [15:0] pc_out, push_data_out;
    wire logic [7:0] flags_out, result_out, io_wdata_out;
    int errors = 0, checks = 0, cyc = 0;
    clbe_core #(.PC_W(16)) DUT (.ref_clk_in(ref_clk_in), .reset_n_in(reset_n_in),
        .start_in(start_in), .op_in(op_in), .rd_val_in(rd_val_in), .rr_val_in(rr_val_in),
        .imm_in(imm_in), .bit_sel_in(bit_sel_in), .offset_in(offset_in),
        .io_rdata_in(io_rdata_in), .z_ptr_in(z_ptr_in), .stack_pc_in(stack_pc_in),
        .next_two_word_in(next_two_word_in), .busy_out(busy_out), .done_out(done_out),
        .pc_out(pc_out), .flags_out(flags_out), .result_out(result_out),
        .result_we_out(result_we_out), .io_wdata_out(io_wdata_out), .io_we_out(io_we_out),
        .push_out(push_out), .push_data_out(push_data_out), .pop_out(pop_out));
    // Clock
    initial begin
        forever #10 ref_clk_in = ~ref_clk_in;
    end
    // Hang guard
    always @(posedge ref_clk_in) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            errors++;
            complete_run;
        end
    end
    // Value comparison
    task chk(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    // Issue one op, check done lands after n cycles and the new pc
    task run(input logic [4:0] op, input int n, input logic [15:0] npc);
        @(posedge ref_clk_in);
        #2 op_in = op;
        start_in = 1'b1;
        @(posedge ref_clk_in);
        #2 start_in = 1'b0;
        repeat (n - 1) @(posedge ref_clk_in);
        #2 chk(done_out, 1);
        chk(pc_out, npc);
        pc = npc;
    endtask
    // One-cycle data op with result and masked flags
    task lg(input logic [4:0] op, input logic [7:0] rd, imm, res, fl, msk);
        rd_val_in = rd;
        imm_in = imm;
        run(op, 1, pc + 16'h0001);
        chk(result_out, res);
        chk(flags_out & msk, fl);
    endtask
    task t_logic;
        lg(`CLBE_OP_OR_IMM, 8'h80, 8'h01, 8'h81, 8'h04, 8'h0E);
        lg(`CLBE_OP_ANDN_IMM, 8'h0F, 8'h0F, 8'h00, 8'h02, 8'h0E);
        lg(`CLBE_OP_TEST_ZN, 8'h80, 8'h00, 8'h80, 8'h04, 8'h0E);
        lg(`CLBE_OP_ADD_ONE, 8'h7F, 8'h00, 8'h80, 8'h0C, 8'h0E);
        lg(`CLBE_OP_SUB_ONE, 8'h80, 8'h00, 8'h7F, 8'h08, 8'h0E);
        lg(`CLBE_OP_ZERO_REG, 8'h5A, 8'h00, 8'h00, 8'h02, 8'h0E);
        lg(`CLBE_OP_FILL_ONES, 8'h00, 8'h00, 8'hFF, 8'h02, 8'h0E);
        $display("logic test finished");
    endtask
    task t_shift;
        rd_val_in = 8'h10;
        imm_in = 8'h20;
        run(`CLBE_OP_CMP_IMM, 1, pc + 16'h0001);
        chk(flags_out & 8'h2F, 8'h05);
        imm_in = 8'h01;
        run(`CLBE_OP_CMP_IMM, 1, pc + 16'h0001);
        chk(flags_out & 8'h2F, 8'h20);
        lg(`CLBE_OP_SHIFT_LEFT, 8'h81, 8'h00, 8'h02, 8'h09, 8'h0F);
        lg(`CLBE_OP_ROTATE_LEFT, 8'h40, 8'h00, 8'h81, 8'h0C, 8'h0F);
        lg(`CLBE_OP_SHIFT_RIGHT, 8'h01, 8'h00, 8'h00, 8'h0B, 8'h0F);
        chk(flags_out, 8'h3B);
        $display("compare and shift test finished");
    endtask
    // Flags here are 3B: every flag bit both ways, offset -3
    task t_branch;
        logic [7:0] fl;
        fl = 8'h3B;
        offset_in = 12'hFFD;
        for (int s = 0; s < 8; s++) begin
            bit_sel_in = s[2:0];
            run(`CLBE_OP_BR_FLAG_SET, fl[s] ? 2 : 1, fl[s] ? pc - 16'h0002 : pc + 16'h0001);
            run(`CLBE_OP_BR_FLAG_CLR, fl[s] ? 1 : 2, fl[s] ? pc + 16'h0001 : pc - 16'h0002);
        end
        chk(flags_out, fl);
        stack_pc_in = 16'h0100;
        run(`CLBE_OP_IRQ_EXIT, 4, 16'h0100);
        chk(flags_out, 8'hBB);
        bit_sel_in = 3'h7;
        run(`CLBE_OP_BR_FLAG_SET, 2, pc - 16'h0002);
        $display("branch test finished");
    endtask
    task t_jump;
        offset_in = 12'h800;
        run(`CLBE_OP_REL_JUMP, 2, pc + 16'hF801);
        z_ptr_in = 16'h1234;
        run(`CLBE_OP_JUMP_PTR, 2, 16'h1234);
        offset_in = 12'h7FF;
        old = pc;
        run(`CLBE_OP_REL_CALL, 3, pc + 16'h0800);
        chk({push_out, push_data_out}, {1'b1, old + 16'h0001});
        z_ptr_in = 16'hABCD;
        old = pc;
        run(`CLBE_OP_CALL_PTR, 3, 16'hABCD);
        chk({push_out, push_data_out}, {1'b1, old + 16'h0001});
        stack_pc_in = 16'h0042;
        run(`CLBE_OP_POP_PC, 4, 16'h0042);
        chk({pop_out, flags_out}, 9'h1BB);
        $display("jump test finished");
    endtask
    task t_skip;
        rd_val_in = 8'h55;
        rr_val_in = 8'h55;
        run(`CLBE_OP_CMP_SKIP_EQ, 2, pc + 16'h0002);
        next_two_word_in = 1'b1;
        run(`CLBE_OP_CMP_SKIP_EQ, 3, pc + 16'h0003);
        rr_val_in = 8'h54;
        run(`CLBE_OP_CMP_SKIP_EQ, 1, pc + 16'h0001);
        rd_val_in = 8'h04;
        bit_sel_in = 3'h2;
        run(`CLBE_OP_SKIP_REG_SET, 3, pc + 16'h0003);
        next_two_word_in = 1'b0;
        run(`CLBE_OP_SKIP_REG_CLR, 1, pc + 16'h0001);
        io_rdata_in = 8'h7F;
        bit_sel_in = 3'h7;
        run(`CLBE_OP_SKIP_IO_CLR, 2, pc + 16'h0002);
        run(`CLBE_OP_SKIP_IO_SET, 1, pc + 16'h0001);
        chk(flags_out, 8'hBB);
        $display("skip test finished");
    endtask
    task t_io;
        io_rdata_in = 8'hA0;
        bit_sel_in = 3'h0;
        run(`CLBE_OP_IO_BIT_SET, 2, pc + 16'h0001);
        chk({io_we_out, io_wdata_out}, 9'h1A1);
        bit_sel_in = 3'h7;
        run(`CLBE_OP_IO_BIT_CLR, 2, pc + 16'h0001);
        chk({io_we_out, io_wdata_out}, 9'h120);
        chk(flags_out, 8'hBB);
        $display("io bit test finished");
    endtask
    // Start held through a busy pointer jump must not launch a second op
    task t_refuse;
        z_ptr_in = 16'h0200;
        @(posedge ref_clk_in);
        #2 op_in = `CLBE_OP_JUMP_PTR;
        start_in = 1'b1;
        @(posedge ref_clk_in);
        #2 op_in = `CLBE_OP_OR_IMM;
        chk(busy_out, 1);
        @(posedge ref_clk_in);
        #2 start_in = 1'b0;
        chk(done_out, 1);
        chk(pc_out, 16'h0200);
        chk(result_we_out, 0);
        chk(busy_out, 0);
        pc = 16'h0200;
        $display("refused start test finished");
    endtask
    task complete_run;
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // Main sequence
    initial begin
        repeat (12) @(posedge ref_clk_in);
        #2 reset_n_in = 1'b1;
        t_logic;
        t_shift;
        t_branch;
        t_jump;
        t_skip;
        t_io;
        t_refuse;
        complete_run;
    end
endmodule
`default_nettype wire
